// ### logic/rirc_pkg.sv
// register map, field positions and reset values of the receiver control bank
package rirc_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W_DEFAULT = 10;
  localparam int unsigned DATA_W         = 8;

  // register offsets
  localparam logic [9:0] CTL_OFFSET = 10'h01A;
  localparam logic [9:0] FB_OFFSET  = 10'h01B;

  // values after reset
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] FB_RESET  = 8'h00;

  // input_receiver_control fields
  localparam int unsigned CTL_TEST_EN_BIT  = 7;
  localparam int unsigned CTL_SEC_DIFF_BIT = 6;
  localparam int unsigned CTL_PRI_DIFF_BIT = 5;
  localparam int unsigned CTL_SEC_EN_BIT   = 4;
  localparam int unsigned CTL_PRI_EN_BIT   = 3;
  localparam int unsigned CTL_PD_CTRL_BIT  = 2;
  localparam int unsigned CTL_OSC_NEG_BIT  = 1;
  localparam int unsigned CTL_OSC_DIFF_BIT = 0;

  // feedback_and_single_ended_select fields
  localparam int unsigned FB_ZD_INT_BIT  = 5;
  localparam int unsigned FB_OSC_FB_BIT  = 4;
  localparam int unsigned FB_ZD_PIN_BIT  = 3;
  localparam int unsigned FB_ZD_DIFF_BIT = 2;
  localparam int unsigned FB_SEC_PIN_BIT = 1;
  localparam int unsigned FB_PRI_PIN_BIT = 0;
  localparam logic [7:0]  FB_RSVD_MASK   = 8'hC0;

endpackage

// ### logic/rirc_byte_reg.sv
// one byte-wide configuration register with write strobe
module rirc_byte_reg #(
  parameter int unsigned WIDTH     = 8,
  parameter logic [7:0]  RESET_VAL = 8'h00
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // stored value
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;

  if (WIDTH != 8) begin : g_width_check
    $error("rirc_byte_reg supports only 8-bit registers");
  end

  always_comb begin
    value_d = value_q;
    if (wr_en) begin
      value_d = wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

endmodule

// ### logic/rirc_top.sv
// receiver control bank for the input loop: two registers and their decode
module rirc_top #(
  parameter int unsigned ADDR_W = rirc_pkg::ADDR_W_DEFAULT
) (
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              ARST_N,
  // register port
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic              REG_WR_STB,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_RD_STB,
  output logic      [7:0]        REG_RDATA,
  output logic                   REG_RD_VALID,
  output logic                   REG_RD_HIT,
  // test reference receiver
  output logic                   TEST_REF_RX_EN,
  // primary_reference_input receiver
  output logic                   PRIMARY_REFERENCE_INPUT_EN,
  output logic                   PRIMARY_REFERENCE_INPUT_DIFF,
  output logic                   PRIMARY_REFERENCE_INPUT_PIN_SEL,
  // secondary_reference_input receiver
  output logic                   SECONDARY_REFERENCE_INPUT_EN,
  output logic                   SECONDARY_REFERENCE_INPUT_DIFF,
  output logic                   SECONDARY_REFERENCE_INPUT_PIN_SEL,
  // oscillator_input receiver
  output logic                   OSCILLATOR_INPUT_DIFF,
  output logic                   OSCILLATOR_INPUT_NEG_SEL,
  // zero_delay_input receiver
  output logic                   ZERO_DELAY_INPUT_EN,
  output logic                   ZERO_DELAY_INPUT_DIFF,
  output logic                   ZERO_DELAY_INPUT_PIN_SEL,
  // input_loop feedback path
  output logic                   INPUT_LOOP_FB_OSC,
  output logic                   INPUT_LOOP_FB_ZD_INTERNAL,
  output logic                   INPUT_LOOP_FB_ZD_EXTERNAL
);

  localparam int unsigned NREG = 2;

  if (ADDR_W < 5) begin : g_addr_check
    $error("rirc_top needs at least 5 address bits");
  end

  // one decoder shared by the write and read paths
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [9:0]        offset);
    addr_hit = (addr == ADDR_W'(offset));
  endfunction

  logic [NREG-1:0]      wr_sel;
  logic [NREG-1:0][7:0] reg_val;
  logic [7:0]           ctl;
  logic [7:0]           fb;

  // register storage
  for (genvar i = 0; i < NREG; i++) begin : g_regs
    localparam logic [9:0] OFS = (i == 0) ? rirc_pkg::CTL_OFFSET : rirc_pkg::FB_OFFSET;
    localparam logic [7:0] RST = (i == 0) ? rirc_pkg::CTL_RESET : rirc_pkg::FB_RESET;
    // reserved bits are stored as written and read back
    assign wr_sel[i] = REG_WR_STB && addr_hit(REG_ADDR, OFS);
    rirc_byte_reg #(
      .WIDTH     (8),
      .RESET_VAL (RST)
    ) u_reg (
      .clk     (CLOCK),
      .arst_n  (ARST_N),
      .wr_en   (wr_sel[i]),
      .wr_data (REG_WDATA),
      .value   (reg_val[i])
    );
  end

  assign ctl = reg_val[0];
  assign fb  = reg_val[1];

  // read path, answer one cycle after the strobe
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  logic       rhit_q;
  logic       rhit_d;

  always_comb begin
    rdata_d  = 8'h00;
    rhit_d   = 1'b0;
    rvalid_d = REG_RD_STB;
    if (REG_RD_STB) begin
      if (addr_hit(REG_ADDR, rirc_pkg::CTL_OFFSET)) begin
        rdata_d = ctl;
        rhit_d  = 1'b1;
      end else if (addr_hit(REG_ADDR, rirc_pkg::FB_OFFSET)) begin
        rdata_d = fb; // full byte incl. reserved bits
        rhit_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      rhit_q   <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      rhit_q   <= rhit_d;
    end
  end

  assign REG_RDATA    = rdata_q;
  assign REG_RD_VALID = rvalid_q;
  assign REG_RD_HIT   = rhit_q;

  // receiver decode straight from the stored bits, so a write shows
  // on the cycle after its strobe
  logic pd_ctrl;
  logic pri_diff;
  logic sec_diff;
  logic osc_diff;
  logic zd_diff;
  logic fb_osc;

  assign pd_ctrl  = ctl[rirc_pkg::CTL_PD_CTRL_BIT];
  assign pri_diff = ctl[rirc_pkg::CTL_PRI_DIFF_BIT];
  assign sec_diff = ctl[rirc_pkg::CTL_SEC_DIFF_BIT];
  assign osc_diff = ctl[rirc_pkg::CTL_OSC_DIFF_BIT];
  assign zd_diff  = fb[rirc_pkg::FB_ZD_DIFF_BIT];
  assign fb_osc   = fb[rirc_pkg::FB_OSC_FB_BIT];

  assign TEST_REF_RX_EN = ctl[rirc_pkg::CTL_TEST_EN_BIT];

  // without power-down control both references stay up
  assign PRIMARY_REFERENCE_INPUT_EN   = !pd_ctrl || ctl[rirc_pkg::CTL_PRI_EN_BIT];
  assign SECONDARY_REFERENCE_INPUT_EN = !pd_ctrl || ctl[rirc_pkg::CTL_SEC_EN_BIT];

  assign PRIMARY_REFERENCE_INPUT_DIFF   = pri_diff;
  assign SECONDARY_REFERENCE_INPUT_DIFF = sec_diff;

  // pin choice only matters single-ended; held low otherwise
  assign PRIMARY_REFERENCE_INPUT_PIN_SEL   = !pri_diff && fb[rirc_pkg::FB_PRI_PIN_BIT];
  assign SECONDARY_REFERENCE_INPUT_PIN_SEL = !sec_diff && fb[rirc_pkg::FB_SEC_PIN_BIT];

  assign OSCILLATOR_INPUT_DIFF    = osc_diff;
  assign OSCILLATOR_INPUT_NEG_SEL = !osc_diff && ctl[rirc_pkg::CTL_OSC_NEG_BIT];

  // zero-delay mode bit is ignored while local feedback is chosen
  assign INPUT_LOOP_FB_OSC         = fb_osc;
  assign INPUT_LOOP_FB_ZD_INTERNAL = !fb_osc && fb[rirc_pkg::FB_ZD_INT_BIT];
  assign INPUT_LOOP_FB_ZD_EXTERNAL = !fb_osc && !fb[rirc_pkg::FB_ZD_INT_BIT];
  assign ZERO_DELAY_INPUT_EN       = INPUT_LOOP_FB_ZD_EXTERNAL;

  assign ZERO_DELAY_INPUT_DIFF    = zd_diff;
  assign ZERO_DELAY_INPUT_PIN_SEL = !zd_diff && fb[rirc_pkg::FB_ZD_PIN_BIT];

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  logic wr_ctl;
  logic wr_fb;
  assign wr_ctl = REG_WR_STB && (REG_ADDR == ADDR_W'(rirc_pkg::CTL_OFFSET));
  assign wr_fb  = REG_WR_STB && (REG_ADDR == ADDR_W'(rirc_pkg::FB_OFFSET));

  sequence s_wr_ctl_bit(int unsigned b, logic v);
    wr_ctl && (REG_WDATA[b] == v);
  endsequence

  sequence s_wr_fb_bit(int unsigned b, logic v);
    wr_fb && (REG_WDATA[b] == v);
  endsequence

  property p_test_en;
    s_wr_ctl_bit(rirc_pkg::CTL_TEST_EN_BIT, 1'b1) |=> TEST_REF_RX_EN;
  endproperty
  a_test_en: assert property (p_test_en) else $error("test rx not enabled");

  property p_sec_diff;
    wr_ctl |=> SECONDARY_REFERENCE_INPUT_DIFF == $past(REG_WDATA[6]);
  endproperty
  a_sec_diff: assert property (p_sec_diff) else $error("secondary mode wrong");

  property p_pri_diff;
    wr_ctl |=> PRIMARY_REFERENCE_INPUT_DIFF == $past(REG_WDATA[5]);
  endproperty
  a_pri_diff: assert property (p_pri_diff) else $error("primary mode wrong");

  property p_both_up;
    s_wr_ctl_bit(rirc_pkg::CTL_PD_CTRL_BIT, 1'b0) |=>
      PRIMARY_REFERENCE_INPUT_EN && SECONDARY_REFERENCE_INPUT_EN;
  endproperty
  a_both_up: assert property (p_both_up) else $error("reference powered down");

  property p_sec_pd;
    (s_wr_ctl_bit(rirc_pkg::CTL_PD_CTRL_BIT, 1'b1) and
     s_wr_ctl_bit(rirc_pkg::CTL_SEC_EN_BIT, 1'b0)) |=> !SECONDARY_REFERENCE_INPUT_EN;
  endproperty
  a_sec_pd: assert property (p_sec_pd) else $error("secondary not powered down");

  property p_pri_pd;
    (s_wr_ctl_bit(rirc_pkg::CTL_PD_CTRL_BIT, 1'b1) and
     s_wr_ctl_bit(rirc_pkg::CTL_PRI_EN_BIT, 1'b0)) |=> !PRIMARY_REFERENCE_INPUT_EN;
  endproperty
  a_pri_pd: assert property (p_pri_pd) else $error("primary not powered down");

  property p_osc_diff;
    wr_ctl |=> OSCILLATOR_INPUT_DIFF == $past(REG_WDATA[0]);
  endproperty
  a_osc_diff: assert property (p_osc_diff) else $error("oscillator mode wrong");

  property p_osc_neg;
    (s_wr_ctl_bit(rirc_pkg::CTL_OSC_DIFF_BIT, 1'b0) and
     s_wr_ctl_bit(rirc_pkg::CTL_OSC_NEG_BIT, 1'b1)) |=> OSCILLATOR_INPUT_NEG_SEL;
  endproperty
  a_osc_neg: assert property (p_osc_neg) else $error("negative pin not chosen");

  property p_fb_osc;
    s_wr_fb_bit(rirc_pkg::FB_OSC_FB_BIT, 1'b1) |=>
      INPUT_LOOP_FB_OSC && !INPUT_LOOP_FB_ZD_INTERNAL && !ZERO_DELAY_INPUT_EN;
  endproperty
  a_fb_osc: assert property (p_fb_osc) else $error("local feedback wrong");

  property p_zd_int;
    (s_wr_fb_bit(rirc_pkg::FB_OSC_FB_BIT, 1'b0) and
     s_wr_fb_bit(rirc_pkg::FB_ZD_INT_BIT, 1'b1)) |=>
      INPUT_LOOP_FB_ZD_INTERNAL && !ZERO_DELAY_INPUT_EN;
  endproperty
  a_zd_int: assert property (p_zd_int) else $error("internal zero delay wrong");

  property p_zd_ext;
    (s_wr_fb_bit(rirc_pkg::FB_OSC_FB_BIT, 1'b0) and
     s_wr_fb_bit(rirc_pkg::FB_ZD_INT_BIT, 1'b0)) |=>
      ZERO_DELAY_INPUT_EN && INPUT_LOOP_FB_ZD_EXTERNAL;
  endproperty
  a_zd_ext: assert property (p_zd_ext) else $error("external zero delay wrong");

  property p_zd_diff;
    wr_fb |=> ZERO_DELAY_INPUT_DIFF == $past(REG_WDATA[2]);
  endproperty
  a_zd_diff: assert property (p_zd_diff) else $error("zero-delay mode wrong");

  property p_zd_pin;
    s_wr_fb_bit(rirc_pkg::FB_ZD_DIFF_BIT, 1'b0) |=>
      ZERO_DELAY_INPUT_PIN_SEL == $past(REG_WDATA[3]);
  endproperty
  a_zd_pin: assert property (p_zd_pin) else $error("zero-delay pin wrong");

  property p_sec_pin;
    (wr_fb ##1 !SECONDARY_REFERENCE_INPUT_DIFF) |->
      SECONDARY_REFERENCE_INPUT_PIN_SEL == $past(REG_WDATA[rirc_pkg::FB_SEC_PIN_BIT]);
  endproperty
  a_sec_pin: assert property (p_sec_pin) else $error("secondary pin wrong");

  property p_pri_pin;
    (wr_fb ##1 !PRIMARY_REFERENCE_INPUT_DIFF) |->
      PRIMARY_REFERENCE_INPUT_PIN_SEL == $past(REG_WDATA[0]);
  endproperty
  a_pri_pin: assert property (p_pri_pin) else $error("primary pin wrong");

  property p_rsvd_read;
    (wr_fb ##1 (REG_RD_STB && !REG_WR_STB &&
                REG_ADDR == ADDR_W'(rirc_pkg::FB_OFFSET))) |=>
      ((REG_RDATA & rirc_pkg::FB_RSVD_MASK) == ($past(REG_WDATA, 2) & rirc_pkg::FB_RSVD_MASK));
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits lost");

  property p_settle;
    wr_ctl ##1 !wr_ctl [*3] |-> $stable(TEST_REF_RX_EN) && $stable(OSCILLATOR_INPUT_DIFF);
  endproperty
  a_settle: assert property (p_settle) else $error("decode changed without write");

  property p_read_answer;
    REG_RD_STB |=> REG_RD_VALID ##0
      (REG_RD_HIT || REG_RDATA == 8'h00);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");

  property p_test_off;
    s_wr_ctl_bit(rirc_pkg::CTL_TEST_EN_BIT, 1'b0) |=> !TEST_REF_RX_EN;
  endproperty
  a_test_off: assert property (p_test_off) else $error("test rx not disabled");

  property p_sec_up;
    (s_wr_ctl_bit(rirc_pkg::CTL_PD_CTRL_BIT, 1'b1) and
     s_wr_ctl_bit(rirc_pkg::CTL_SEC_EN_BIT, 1'b1)) |=> SECONDARY_REFERENCE_INPUT_EN;
  endproperty
  a_sec_up: assert property (p_sec_up) else $error("secondary not enabled");

  property p_pri_up;
    (s_wr_ctl_bit(rirc_pkg::CTL_PD_CTRL_BIT, 1'b1) and
     s_wr_ctl_bit(rirc_pkg::CTL_PRI_EN_BIT, 1'b1)) |=> PRIMARY_REFERENCE_INPUT_EN;
  endproperty
  a_pri_up: assert property (p_pri_up) else $error("primary not enabled");

  property p_osc_pos;
    s_wr_ctl_bit(rirc_pkg::CTL_OSC_DIFF_BIT, 1'b1) |=> !OSCILLATOR_INPUT_NEG_SEL;
  endproperty
  a_osc_pos: assert property (p_osc_pos) else $error("pin select in diff mode");

  property p_zd_ignored;
    (s_wr_fb_bit(rirc_pkg::FB_OSC_FB_BIT, 1'b1) and
     s_wr_fb_bit(rirc_pkg::FB_ZD_INT_BIT, 1'b0)) |=>
      !ZERO_DELAY_INPUT_EN && !INPUT_LOOP_FB_ZD_EXTERNAL;
  endproperty
  a_zd_ignored: assert property (p_zd_ignored) else $error("mode bit acted on");

  property p_sec_forced;
    s_wr_ctl_bit(rirc_pkg::CTL_SEC_DIFF_BIT, 1'b1) |=> !SECONDARY_REFERENCE_INPUT_PIN_SEL;
  endproperty
  a_sec_forced: assert property (p_sec_forced) else $error("secondary pin in diff");

  property p_pri_forced;
    s_wr_ctl_bit(rirc_pkg::CTL_PRI_DIFF_BIT, 1'b1) |=> !PRIMARY_REFERENCE_INPUT_PIN_SEL;
  endproperty
  a_pri_forced: assert property (p_pri_forced) else $error("primary pin in diff");

  // decode fed by one register moves only on a write to that register
  property p_ctl_hold;
    !wr_ctl |=> $stable(TEST_REF_RX_EN) && $stable(OSCILLATOR_INPUT_DIFF) &&
      $stable(OSCILLATOR_INPUT_NEG_SEL) && $stable(PRIMARY_REFERENCE_INPUT_EN) &&
      $stable(SECONDARY_REFERENCE_INPUT_EN) && $stable(PRIMARY_REFERENCE_INPUT_DIFF);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("control decode drifted");

  property p_fb_hold;
    !wr_fb |=> $stable(INPUT_LOOP_FB_OSC) && $stable(INPUT_LOOP_FB_ZD_INTERNAL) &&
      $stable(INPUT_LOOP_FB_ZD_EXTERNAL) && $stable(ZERO_DELAY_INPUT_EN) &&
      $stable(ZERO_DELAY_INPUT_DIFF) && $stable(ZERO_DELAY_INPUT_PIN_SEL);
  endproperty
  a_fb_hold: assert property (p_fb_hold) else $error("feedback decode drifted");

  property p_rd_fb;
    (REG_RD_STB && REG_ADDR == ADDR_W'(rirc_pkg::FB_OFFSET)) |=> REG_RDATA == $past(fb);
  endproperty
  a_rd_fb: assert property (p_rd_fb) else $error("stored byte not returned");

  property p_unmapped;
    (REG_RD_STB && REG_ADDR != ADDR_W'(rirc_pkg::CTL_OFFSET) &&
     REG_ADDR != ADDR_W'(rirc_pkg::FB_OFFSET)) |=>
      REG_RD_VALID && !REG_RD_HIT && REG_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");

endmodule

// ### tb/rirc_bench.sv
// self-checking bench for the receiver control bank
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, (e), (g)); end end

module rirc_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [9:0] CTL = rirc_pkg::CTL_OFFSET;
  localparam logic [9:0] FB  = rirc_pkg::FB_OFFSET;

  logic       clock, arst_n, reg_wr_stb, reg_rd_stb;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, rd_data;
  logic       rd_valid, rd_hit, test_en, pri_en, pri_diff, pri_pin;
  logic       sec_en, sec_diff, sec_pin, osc_diff, osc_neg;
  logic       zd_en, zd_diff, zd_pin, fb_osc, zd_int, zd_ext;
  int         n_errors, tests_run;
  // one row per mode mix: pd control on/off, every feedback choice, reserved bits
  logic [7:0] ctl_tab [7] = '{8'h80, 8'h6C, 8'h14, 8'h02, 8'h03, 8'h9F, 8'h7B};
  logic [7:0] fb_tab  [7] = '{8'h30, 8'h20, 8'h0B, 8'h04, 8'hC8, 8'hFF, 8'h13};

  rirc_top dut (
    .CLOCK(clock), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WR_STB(reg_wr_stb),
    .REG_WDATA(reg_wdata), .REG_RD_STB(reg_rd_stb), .REG_RDATA(rd_data),
    .REG_RD_VALID(rd_valid), .REG_RD_HIT(rd_hit), .TEST_REF_RX_EN(test_en),
    .PRIMARY_REFERENCE_INPUT_EN(pri_en), .PRIMARY_REFERENCE_INPUT_DIFF(pri_diff),
    .PRIMARY_REFERENCE_INPUT_PIN_SEL(pri_pin), .SECONDARY_REFERENCE_INPUT_EN(sec_en),
    .SECONDARY_REFERENCE_INPUT_DIFF(sec_diff), .SECONDARY_REFERENCE_INPUT_PIN_SEL(sec_pin),
    .OSCILLATOR_INPUT_DIFF(osc_diff), .OSCILLATOR_INPUT_NEG_SEL(osc_neg),
    .ZERO_DELAY_INPUT_EN(zd_en), .ZERO_DELAY_INPUT_DIFF(zd_diff),
    .ZERO_DELAY_INPUT_PIN_SEL(zd_pin), .INPUT_LOOP_FB_OSC(fb_osc),
    .INPUT_LOOP_FB_ZD_INTERNAL(zd_int), .INPUT_LOOP_FB_ZD_EXTERNAL(zd_ext)
  );

  task automatic wrap_up;
    $display("checks run %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr   <= a;
    reg_wdata  <= d;
    reg_wr_stb <= 1'h1;
    @(posedge clock);
    reg_wr_stb <= 1'h0;
  endtask

  // read answers exactly one cycle after the strobe, then drops back to idle
  task automatic rd(input logic [9:0] a, input logic h, input logic [7:0] d);
    @(posedge clock);
    reg_addr   <= a;
    reg_rd_stb <= 1'h1;
    @(posedge clock);
    reg_rd_stb <= 1'h0;
    #1;
    `CHK("rd_valid", 1'h1, rd_valid)
    `CHK("rd_hit", h, rd_hit)
    `CHK("rd_data", d, rd_data)
    @(posedge clock);
    #1;
    `CHK("rd_valid_idle", 1'h0, rd_valid)
    `CHK("rd_data_idle", 8'h00, rd_data)
  endtask

  // expected receiver state worked out from the two stored bytes
  task automatic dec(input logic [7:0] c, input logic [7:0] f);
    #1;
    `CHK("test_en", c[7], test_en)
    `CHK("sec_diff", c[6], sec_diff)
    `CHK("sec_pin", ~c[6] & f[1], sec_pin)
    `CHK("pri_diff", c[5], pri_diff)
    `CHK("pri_pin", ~c[5] & f[0], pri_pin)
    `CHK("sec_en", ~c[2] | c[4], sec_en)
    `CHK("pri_en", ~c[2] | c[3], pri_en)
    `CHK("osc_diff", c[0], osc_diff)
    `CHK("osc_neg", ~c[0] & c[1], osc_neg)
    `CHK("fb_osc", f[4], fb_osc)
    `CHK("zd_int", ~f[4] & f[5], zd_int)
    `CHK("zd_ext", ~f[4] & ~f[5], zd_ext)
    `CHK("zd_en", ~f[4] & ~f[5], zd_en)
    `CHK("zd_diff", f[2], zd_diff)
    `CHK("zd_pin", ~f[2] & f[3], zd_pin)
  endtask

  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  // hang guard, far beyond the sequence length
  initial begin
    #2000000;
    n_errors++;
    wrap_up;
  end

  initial begin
    n_errors   = 0;
    tests_run  = 0;
    arst_n     = 1'h0;
    reg_addr   = 10'h000;
    reg_wdata  = 8'h00;
    reg_wr_stb = 1'h0;
    reg_rd_stb = 1'h0;
    repeat (9) @(posedge clock);
    dec(8'h00, 8'h00);
    @(posedge clock);
    arst_n <= 1'h1;
    rd(CTL, 1'h1, 8'h00);
    rd(FB, 1'h1, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(CTL, ctl_tab[i]);
      wr(FB, fb_tab[i]);
      dec(ctl_tab[i], fb_tab[i]);
      rd(CTL, 1'h1, ctl_tab[i]);
      rd(FB, 1'h1, fb_tab[i]);
    end
    // unmapped place: write dropped, read answers empty
    wr(10'h01C, 8'hFF);
    rd(10'h01C, 1'h0, 8'h00);
    rd(CTL, 1'h1, 8'h7B);
    // write and read together: change lands after the edge, read sees old byte
    @(posedge clock);
    reg_addr   <= CTL;
    reg_wdata  <= 8'h80;
    reg_wr_stb <= 1'h1;
    reg_rd_stb <= 1'h1;
    #1;
    `CHK("test_en_early", 1'h0, test_en)
    @(posedge clock);
    reg_wr_stb <= 1'h0;
    reg_rd_stb <= 1'h0;
    #1;
    `CHK("test_en_late", 1'h1, test_en)
    `CHK("rd_data_old", 8'h7B, rd_data)
    // back to back writes, then the reserved bits read on the very next edge
    @(posedge clock);
    reg_addr   <= CTL;
    reg_wdata  <= 8'h15;
    reg_wr_stb <= 1'h1;
    @(posedge clock);
    reg_addr   <= FB;
    reg_wdata  <= 8'hA4;
    @(posedge clock);
    reg_wr_stb <= 1'h0;
    reg_rd_stb <= 1'h1;
    @(posedge clock);
    reg_rd_stb <= 1'h0;
    #1;
    `CHK("rd_data_b2b", 8'hA4, rd_data)
    dec(8'h15, 8'hA4);
    // one quiet edge so the read checks finish before reset
    @(posedge clock);
    // second reset in mid-run clears both bytes
    @(posedge clock);
    arst_n <= 1'h0;
    @(posedge clock);
    dec(8'h00, 8'h00);
    @(posedge clock);
    arst_n <= 1'h1;
    rd(FB, 1'h1, 8'h00);
    wrap_up;
  end
endmodule
